// [cpu_timing_pkg.sv]
// shared constants, types and opcode classes for the instruction timing core
`default_nettype none
package cpu_timing_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_MAX_MHZ = 25;
    localparam logic [3:0] MAX_CYCLES = 4'h8;
    localparam int RAM_DEPTH = 256;
    localparam int SFR_DEPTH = 128;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [3:0] CNT_IDLE = 4'h0;
    localparam logic [3:0] CNT_LAST = 4'h1;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // opcodes that the decoder handles by name rather than by the bytes-equal-cycles default
    localparam logic [7:0] OP_MUL = 8'ha4;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_MOVC_DPTR = 8'h93;
    localparam logic [7:0] OP_MOVC_PC = 8'h83;
    localparam logic [7:0] OP_MOVX_RD_DPTR = 8'he0;
    localparam logic [7:0] OP_MOVX_WR_DPTR = 8'hf0;
    localparam logic [7:0] OP_MOVX_RD_RI0 = 8'he2;
    localparam logic [7:0] OP_MOVX_RD_RI1 = 8'he3;
    localparam logic [7:0] OP_MOVX_WR_RI0 = 8'hf2;
    localparam logic [7:0] OP_MOVX_WR_RI1 = 8'hf3;
    localparam logic [7:0] OP_JBC = 8'h10;
    localparam logic [7:0] OP_JB = 8'h20;
    localparam logic [7:0] OP_JNB = 8'h30;
    localparam logic [7:0] OP_JC = 8'h40;
    localparam logic [7:0] OP_JNC = 8'h50;
    localparam logic [7:0] OP_JZ = 8'h60;
    localparam logic [7:0] OP_JNZ = 8'h70;
    localparam logic [7:0] OP_DJNZ_DIR = 8'hd5;
    localparam logic [7:0] OP_MOV_DPTR = 8'h90;
    localparam logic [7:0] OP_INC_DPTR = 8'ha3;
    localparam logic [4:0] OP_DJNZ_RN_HI = 5'b11011;
    localparam logic [5:0] OP_CJNE_HI = 6'b101101;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;

    typedef enum logic [1:0] {
        FL_NONE = 2'b00,
        FL_READ = 2'b01,
        FL_WRITE = 2'b10
    } flash_op_t;

    typedef enum logic [1:0] {
        AD_DPTR = 2'b00,
        AD_A_DPTR = 2'b01,
        AD_A_PC = 2'b10,
        AD_RI = 2'b11
    } flash_addr_mode_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_STEP = 2'b10
    } dbg_state_t;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cyc;
        logic cond;
        flash_op_t fop;
        flash_addr_mode_t amode;
    } decode_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic sfr;
        logic [7:0] wdata;
    } mem_req_t;
endpackage
`default_nettype wire

// [cpu_core_instruction_timing.sv]
// instruction timing sequencer with data memories, flash byte access and debug halt
`default_nettype none
// Function
// - standard opcode encodings decoded unchanged
// - timing counted in plain clock cycles
// - default cycles equal instruction byte count
// - untaken conditional branch one cycle shorter
// - no instruction exceeds eight cycles
// - cycle classes follow the instruction count table
// - issue up to one instruction per clock
// - internal data ram of 256 bytes
// - special function space of 128 bytes
// - software reads and writes flash bytewise
// - breakpoints, halt, run, step, memory access
// - debug uses no application resources
// - debug traffic arrives from two-wire link
// - external data moves target program flash
// - external read via pointer, one byte, three cycles
// - code read relative pointer, one byte, three cycles
module cpu_core_instruction_timing (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [15:0] op_pc,
    input wire logic cond_taken,
    input wire logic [7:0] acc,
    input wire logic [15:0] dptr,
    input wire logic [7:0] ri_val,
    input wire cpu_timing_pkg::mem_req_t core_mem,
    input wire logic dbg_halt,
    input wire logic dbg_run,
    input wire logic dbg_step,
    input wire logic dbg_bp_en,
    input wire logic [15:0] dbg_bp_addr,
    input wire cpu_timing_pkg::mem_req_t dbg_mem,
    output logic op_ready,
    output logic retire,
    output logic [3:0] busy_cycles,
    output logic [1:0] op_len,
    output logic halted,
    output logic flash_req,
    output logic flash_we,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid
);
    // decode: default is cycles equal to length, with the listed exceptions
    function automatic cpu_timing_pkg::decode_t decode(input logic [7:0] op);
        cpu_timing_pkg::decode_t d;
        d = '0;
        d.len = cpu_timing_pkg::LEN_1;
        d.fop = cpu_timing_pkg::FL_NONE;
        d.amode = cpu_timing_pkg::AD_DPTR;
        if (op[3:0] == 4'h4 || op[3:0] == 4'h5) begin
            d.len = cpu_timing_pkg::LEN_2;
        end
        if (op[3:0] == 4'h1) begin
            d.len = cpu_timing_pkg::LEN_2;
        end
        if (op == cpu_timing_pkg::OP_MOV_DPTR) begin
            d.len = cpu_timing_pkg::LEN_3;
        end
        d.cyc = {2'b00, d.len};
        case (op)
            cpu_timing_pkg::OP_MUL: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = cpu_timing_pkg::CYC_4;
            end
            cpu_timing_pkg::OP_DIV: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = cpu_timing_pkg::MAX_CYCLES;
            end
            cpu_timing_pkg::OP_INC_DPTR: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = {2'b00, cpu_timing_pkg::LEN_1};
            end
            cpu_timing_pkg::OP_MOVC_DPTR, cpu_timing_pkg::OP_MOVC_PC: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = cpu_timing_pkg::CYC_3;
                d.fop = cpu_timing_pkg::FL_READ;
                d.amode = (op == cpu_timing_pkg::OP_MOVC_PC) ? cpu_timing_pkg::AD_A_PC
                                                             : cpu_timing_pkg::AD_A_DPTR;
            end
            cpu_timing_pkg::OP_MOVX_RD_DPTR, cpu_timing_pkg::OP_MOVX_RD_RI0,
            cpu_timing_pkg::OP_MOVX_RD_RI1: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = cpu_timing_pkg::CYC_3;
                d.fop = cpu_timing_pkg::FL_READ;
                d.amode = (op == cpu_timing_pkg::OP_MOVX_RD_DPTR) ? cpu_timing_pkg::AD_DPTR
                                                                  : cpu_timing_pkg::AD_RI;
            end
            cpu_timing_pkg::OP_MOVX_WR_DPTR, cpu_timing_pkg::OP_MOVX_WR_RI0,
            cpu_timing_pkg::OP_MOVX_WR_RI1: begin
                d.len = cpu_timing_pkg::LEN_1;
                d.cyc = cpu_timing_pkg::CYC_3;
                d.fop = cpu_timing_pkg::FL_WRITE;
                d.amode = (op == cpu_timing_pkg::OP_MOVX_WR_DPTR) ? cpu_timing_pkg::AD_DPTR
                                                                  : cpu_timing_pkg::AD_RI;
            end
            cpu_timing_pkg::OP_JC, cpu_timing_pkg::OP_JNC, cpu_timing_pkg::OP_JZ,
            cpu_timing_pkg::OP_JNZ: begin
                d.len = cpu_timing_pkg::LEN_2;
                d.cyc = {2'b00, cpu_timing_pkg::LEN_2};
                d.cond = 1'b1;
            end
            cpu_timing_pkg::OP_JBC, cpu_timing_pkg::OP_JB, cpu_timing_pkg::OP_JNB,
            cpu_timing_pkg::OP_DJNZ_DIR: begin
                d.len = cpu_timing_pkg::LEN_3;
                d.cyc = cpu_timing_pkg::CYC_3;
                d.cond = 1'b1;
            end
            default: begin
                if (op[7:3] == cpu_timing_pkg::OP_DJNZ_RN_HI) begin
                    d.len = cpu_timing_pkg::LEN_2;
                    d.cyc = {2'b00, cpu_timing_pkg::LEN_2};
                    d.cond = 1'b1;
                end else if (op[7:2] == cpu_timing_pkg::OP_CJNE_HI) begin
                    d.len = cpu_timing_pkg::LEN_3;
                    d.cyc = cpu_timing_pkg::CYC_3;
                    d.cond = 1'b1;
                end
            end
        endcase
        return d;
    endfunction

    // storage held only for the application; debug touches it only through the port
    logic [7:0] ram [cpu_timing_pkg::RAM_DEPTH];
    logic [7:0] sfr [cpu_timing_pkg::SFR_DEPTH];

    cpu_timing_pkg::decode_t dec;
    cpu_timing_pkg::dbg_state_t dbg_q, dbg_d;
    cpu_timing_pkg::mem_req_t mreq;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] total;
    logic accept, bp_hit, can_issue;
    logic ready_q, ready_d;
    logic retire_q, retire_d;
    logic [1:0] len_q, len_d;
    logic freq_q, freq_d;
    logic fwe_q, fwe_d;
    logic [15:0] faddr_q, faddr_d;
    logic [7:0] fwdata_q, fwdata_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic halted_q;

    always_comb begin
        dec = decode(opcode);
        // taken branch adds one; untaken keeps the shorter base count
        total = dec.cyc + {3'b000, dec.cond & cond_taken};
        // a stepped instruction ignores its breakpoint so the step can move on
        bp_hit = dbg_bp_en && (op_pc == dbg_bp_addr) && (dbg_q == cpu_timing_pkg::ST_RUN);
        can_issue = (dbg_q == cpu_timing_pkg::ST_RUN) || (dbg_q == cpu_timing_pkg::ST_STEP);
        accept = op_valid && ready_q && can_issue && !bp_hit && !dbg_halt;
        dbg_d = dbg_q;
        case (dbg_q)
            cpu_timing_pkg::ST_RUN: begin
                if (dbg_halt || (op_valid && ready_q && bp_hit)) begin
                    dbg_d = cpu_timing_pkg::ST_HALT;
                end
            end
            cpu_timing_pkg::ST_HALT: begin
                if (dbg_run) begin
                    dbg_d = cpu_timing_pkg::ST_RUN;
                end else if (dbg_step) begin
                    dbg_d = cpu_timing_pkg::ST_STEP;
                end
            end
            cpu_timing_pkg::ST_STEP: begin
                if (accept) begin
                    dbg_d = cpu_timing_pkg::ST_HALT;
                end
            end
            default: begin
                dbg_d = cpu_timing_pkg::ST_HALT;
            end
        endcase
        cnt_d = (cnt_q == cpu_timing_pkg::CNT_IDLE) ? cnt_q : cnt_q - 4'h1;
        len_d = len_q;
        if (accept) begin
            cnt_d = (total > cpu_timing_pkg::MAX_CYCLES) ? cpu_timing_pkg::MAX_CYCLES
                                                         : total;
            len_d = dec.len;
        end
        retire_d = (cnt_q == cpu_timing_pkg::CNT_LAST);
        // new instruction may enter in the last cycle of the previous one
        ready_d = (cnt_d <= cpu_timing_pkg::CNT_LAST);
    end

    always_comb begin
        freq_d = accept && (dec.fop != cpu_timing_pkg::FL_NONE);
        fwe_d = accept && (dec.fop == cpu_timing_pkg::FL_WRITE);
        faddr_d = faddr_q;
        fwdata_d = fwdata_q;
        if (freq_d) begin
            case (dec.amode)
                cpu_timing_pkg::AD_DPTR: faddr_d = dptr;
                cpu_timing_pkg::AD_A_DPTR: faddr_d = dptr + {8'h00, acc};
                cpu_timing_pkg::AD_A_PC: faddr_d = op_pc + {8'h00, acc};
                cpu_timing_pkg::AD_RI: faddr_d = {8'h00, ri_val};
                default: faddr_d = dptr;
            endcase
            fwdata_d = acc;
        end
    end

    // memory port: the debug side is served only while the core stands still
    always_comb begin
        mreq = (dbg_q == cpu_timing_pkg::ST_HALT) ? dbg_mem : core_mem;
        rvalid_d = mreq.req && !mreq.we;
        rdata_d = rdata_q;
        if (rvalid_d) begin
            rdata_d = mreq.sfr ? sfr[mreq.addr[6:0]] : ram[mreq.addr];
        end
    end

    always_ff @(posedge core_clk) begin
        if (mreq.req && mreq.we) begin
            if (mreq.sfr) begin
                sfr[mreq.addr[6:0]] <= mreq.wdata;
            end else begin
                ram[mreq.addr] <= mreq.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dbg_q <= cpu_timing_pkg::ST_RUN;
            cnt_q <= cpu_timing_pkg::CNT_IDLE;
            ready_q <= 1'b1;
            retire_q <= 1'b0;
            len_q <= 2'h0;
            freq_q <= 1'b0;
            fwe_q <= 1'b0;
            faddr_q <= cpu_timing_pkg::PC_RESET;
            fwdata_q <= cpu_timing_pkg::BYTE_RESET;
            rdata_q <= cpu_timing_pkg::BYTE_RESET;
            rvalid_q <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            // registered copy keeps the halt flag glitch free at the pin
            halted_q <= (dbg_d == cpu_timing_pkg::ST_HALT);
            dbg_q <= dbg_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            retire_q <= retire_d;
            len_q <= len_d;
            freq_q <= freq_d;
            fwe_q <= fwe_d;
            faddr_q <= faddr_d;
            fwdata_q <= fwdata_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign op_ready = ready_q;
    assign retire = retire_q;
    assign busy_cycles = cnt_q;
    assign op_len = len_q;
    assign halted = halted_q;
    assign flash_req = freq_q;
    assign flash_we = fwe_q;
    assign flash_addr = faddr_q;
    assign flash_wdata = fwdata_q;
    assign mem_rdata = rdata_q;
    assign mem_rvalid = rvalid_q;
endmodule
`default_nettype wire

// [cpu_core_instruction_timing_properties.sv]
// port checker for the instruction timing core
`default_nettype none
module cpu_core_instruction_timing_properties (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [7:0] opcode,
    input wire logic [15:0] op_pc,
    input wire logic cond_taken,
    input wire logic [7:0] acc,
    input wire logic [15:0] dptr,
    input wire cpu_timing_pkg::mem_req_t core_mem,
    input wire logic dbg_halt,
    input wire logic dbg_run,
    input wire logic dbg_step,
    input wire logic dbg_bp_en,
    input wire logic [15:0] dbg_bp_addr,
    input wire cpu_timing_pkg::mem_req_t dbg_mem,
    input wire logic op_ready,
    input wire logic retire,
    input wire logic [3:0] busy_cycles,
    input wire logic halted,
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic mem_rvalid
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    logic acc_ok;
    logic rd_req;
    // a breakpoint match blocks issue in run state
    assign acc_ok = op_valid && op_ready && !halted && !dbg_halt
        && !(dbg_bp_en && op_pc == dbg_bp_addr);
    assign rd_req = halted ? (dbg_mem.req && !dbg_mem.we) : (core_mem.req && !core_mem.we);
    busy_cap_a: assert property (busy_cycles <= cpu_timing_pkg::MAX_CYCLES)
        else $error("busy count above eight");
    one_cycle_a: assert property (
        acc_ok && opcode == 8'h28 |=> op_ready && busy_cycles == 4'h1 ##1 retire)
        else $error("single byte op not one cycle");
    branch_len_a: assert property (
        acc_ok && opcode == 8'h60 |=> busy_cycles == ($past(cond_taken) ? 4'h3 : 4'h2))
        else $error("branch length wrong");
    div_len_a: assert property (
        acc_ok && opcode == 8'h84 |=> !op_ready [*7] ##1 op_ready)
        else $error("divide not eight cycles");
    xread_a: assert property (
        acc_ok && opcode == 8'he0 |=> flash_req && !flash_we
        && flash_addr == $past(dptr) && busy_cycles == 4'h3) else $error("pointer read wrong");
    code_read_a: assert property (
        acc_ok && opcode == 8'h93 |=> flash_req && busy_cycles == 4'h3
        && flash_addr == $past(dptr) + {8'h00, $past(acc)}) else $error("code read wrong");
    xwrite_a: assert property (
        acc_ok && opcode == 8'hf0 |=> flash_req && flash_we && flash_wdata == $past(acc))
        else $error("flash write wrong");
    last_retire_a: assert property (busy_cycles == 4'h1 |=> retire)
        else $error("no retire after last cycle");
    halt_freeze_a: assert property (
        halted && !dbg_step |=> busy_cycles <= $past(busy_cycles))
        else $error("issue while halted");
    resume_a: assert property (halted && dbg_run && !dbg_halt |=> !halted)
        else $error("run did not resume");
    rd_answer_a: assert property (rd_req |=> mem_rvalid)
        else $error("read not answered");
    cover property (acc_ok && opcode == 8'h84);
    cover property (halted && dbg_step);
    cover property (halted && mem_rvalid);
    cover property (flash_req && flash_we);
endmodule
bind cpu_core_instruction_timing cpu_core_instruction_timing_properties
    cpu_core_instruction_timing_properties_inst (.core_clk(core_clk), .srst(srst),
    .op_valid(op_valid), .opcode(opcode), .op_pc(op_pc), .cond_taken(cond_taken),
    .acc(acc), .dptr(dptr), .core_mem(core_mem), .dbg_halt(dbg_halt), .dbg_run(dbg_run),
    .dbg_step(dbg_step), .dbg_bp_en(dbg_bp_en), .dbg_bp_addr(dbg_bp_addr),
    .dbg_mem(dbg_mem), .op_ready(op_ready), .retire(retire), .busy_cycles(busy_cycles),
    .halted(halted), .flash_req(flash_req), .flash_we(flash_we), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .mem_rvalid(mem_rvalid));
`default_nettype wire

// [flash_model.sv]
// program flash partner: byte store fed by the core's flash accesses
`default_nettype none
module flash_model (
    input wire logic core_clk,
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic [15:0] probe_addr,
    output var logic [7:0] probe_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] store [logic [15:0]];
    // unwritten bytes read as erased ones
    always @(posedge core_clk) begin
        if (flash_req === 1'b1 && flash_we === 1'b1) begin
            store[flash_addr] = flash_wdata;
        end
        probe_byte <= store.exists(probe_addr) ? store[probe_addr] : 8'hff;
    end
endmodule
`default_nettype wire

// [test_cpu_core_instruction_timing.sv]
// self-checking bench for the instruction timing core
`default_nettype none
module test_cpu_core_instruction_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, srst, op_valid, cond_taken, dbg_halt, dbg_run, dbg_step, dbg_bp_en;
    logic op_ready, retire, halted, flash_req, flash_we, mem_rvalid;
    logic [7:0] opcode, acc, ri_val, flash_wdata, mem_rdata, probe_byte, last_a;
    logic [15:0] op_pc, dptr, dbg_bp_addr, flash_addr, last_d;
    logic [3:0] busy_cycles;
    logic [1:0] op_len;
    logic [25:0] fe;
    cpu_timing_pkg::mem_req_t core_mem, dbg_mem;
    int bad_count, samples_checked, cyc, i, j;
    int exp_t[$];
    logic [25:0] exp_f[$];
    logic [7:0] exp_d[$];
    logic [7:0] ram [256];
    logic [7:0] sfr [128];
    logic [7:0] tops [24] = '{8'h28, 8'h24, 8'h90, 8'ha3, 8'ha4, 8'h84, 8'h93, 8'h83, 8'he0,
        8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3, 8'h60, 8'h70, 8'h40, 8'h50, 8'hd8, 8'h20, 8'h30,
        8'h10, 8'hb4, 8'hd5};
    // upper bit marks a branch that gains a cycle when taken
    logic [4:0] tcyc [24] = '{5'h01, 5'h02, 5'h03, 5'h01, 5'h04, 5'h08, 5'h03, 5'h03, 5'h03,
        5'h03, 5'h03, 5'h03, 5'h03, 5'h03, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h13, 5'h13,
        5'h13, 5'h13, 5'h13};
    cpu_core_instruction_timing cpu_core_instruction_timing_inst (.core_clk(core_clk),
        .srst(srst), .op_valid(op_valid), .opcode(opcode), .op_pc(op_pc),
        .cond_taken(cond_taken), .acc(acc), .dptr(dptr), .ri_val(ri_val), .core_mem(core_mem),
        .dbg_halt(dbg_halt), .dbg_run(dbg_run), .dbg_step(dbg_step), .dbg_bp_en(dbg_bp_en),
        .dbg_bp_addr(dbg_bp_addr), .dbg_mem(dbg_mem), .op_ready(op_ready), .retire(retire),
        .busy_cycles(busy_cycles), .op_len(op_len), .halted(halted), .flash_req(flash_req),
        .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
    flash_model flash_model_inst (.core_clk(core_clk), .flash_req(flash_req),
        .flash_we(flash_we), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .probe_addr(last_d), .probe_byte(probe_byte));
    task automatic chk_time(int got, int exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t retire cycle got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_data(logic [25:0] got, logic [25:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(logic [7:0] op, logic c, int n);
        logic ck;
        logic [15:0] fa;
        int k;
        last_a = 8'($urandom);
        last_d = 16'($urandom);
        fa = 16'($urandom);
        ck = op inside {8'h93, 8'h83, 8'he0, 8'hf0};
        opcode <= op;
        op_valid <= 1'b1;
        cond_taken <= c;
        acc <= last_a;
        dptr <= last_d;
        op_pc <= fa;
        ri_val <= 8'($urandom);
        fa = (op == 8'h83) ? fa + {8'h00, last_a}
            : last_d + ((op == 8'h93) ? {8'h00, last_a} : 16'h0);
        @(negedge core_clk);
        for (k = 0; k < 20 && op_ready !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        @(posedge core_clk);
        exp_t.push_back(cyc + n);
        if (op inside {8'h93, 8'h83, 8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3}) begin
            exp_f.push_back({ck, op[7:4] == 4'hf, ck ? fa : 16'h0, last_a});
        end
    endtask
    task automatic mem_acc(logic dbg, logic we, logic sf, logic [7:0] ad, logic [7:0] wd);
        if (dbg) begin
            dbg_mem <= '{req: 1'b1, we: we, addr: ad, sfr: sf, wdata: wd};
        end else begin
            core_mem <= '{req: 1'b1, we: we, addr: ad, sfr: sf, wdata: wd};
        end
        @(posedge core_clk);
        if (we && sf) begin
            sfr[ad[6:0]] = wd;
        end else if (we) begin
            ram[ad] = wd;
        end else begin
            exp_d.push_back(sf ? sfr[ad[6:0]] : ram[ad]);
        end
    endtask
    task automatic idle(int n, string what);
        op_valid <= 1'b0;
        core_mem <= '0;
        dbg_mem <= '0;
        repeat (n) @(posedge core_clk);
        $display("test done: %s", what);
    endtask
    always @(negedge core_clk) begin
        if (!srst && retire !== 1'b0) begin
            chk_time(cyc, exp_t.size() > 0 ? exp_t.pop_front() : -1);
        end
        if (!srst && flash_req !== 1'b0) begin
            fe = exp_f.size() > 0 ? exp_f.pop_front() : '1;
            chk_data({fe[25], flash_we, fe[25] ? flash_addr : 16'h0, flash_wdata}, fe);
        end
        if (!srst && mem_rvalid !== 1'b0) begin
            chk_data({18'h0, mem_rdata}, {18'h0, exp_d.pop_front()});
        end
        cyc++;
    end
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // whole run is well under a thousand cycles
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
    initial begin
        {srst, op_valid, cond_taken, dbg_halt, dbg_run, dbg_step, dbg_bp_en} = 7'h40;
        {opcode, acc, ri_val, op_pc, dptr, dbg_bp_addr} = '0;
        core_mem = '0;
        dbg_mem = '0;
        void'($urandom(32'h925d06b2));
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        chk_data({15'h0, op_ready, retire, busy_cycles, halted, flash_req, mem_rvalid, op_len},
            26'h400);
        @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 24; i++) begin
                issue(tops[i], j[0], int'(tcyc[i][3:0]) + (tcyc[i][4] & j[0]));
            end
        end
        issue(8'hf0, 1'b0, 3);
        idle(12, "cycle table");
        chk_data({18'h0, probe_byte}, {18'h0, last_a});
        for (i = 0; i < 8; i++) begin
            mem_acc(1'b0, i < 4, i[0], 8'((i % 4) * 85), 8'($urandom));
        end
        idle(3, "data memory");
        dbg_halt <= 1'b1;
        @(posedge core_clk);
        dbg_halt <= 1'b0;
        dbg_step <= 1'b1;
        @(negedge core_clk);
        chk_data({25'h0, halted}, 26'h1);
        @(posedge core_clk);
        dbg_step <= 1'b0;
        issue(8'h28, 1'b0, 1);
        idle(5, "step after halt");
        chk_time(exp_t.size() + exp_f.size() + exp_d.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
